// ===== cmp_pkg.sv
// Shared constants, register layout and types of the dual comparator control block
`default_nettype none

package cmp_pkg;

    // ****************************************
    // Register map and field layout
    // ****************************************
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam int RES_B_BIT  = 7;
    localparam int RES_A_BIT  = 6;
    localparam int INV_B_BIT  = 5;
    localparam int INV_A_BIT  = 4;
    localparam int SWITCH_BIT = 3;
    localparam int MODE_MSB   = 2;
    localparam int MODE_LSB   = 0;
    localparam int SETTLED_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SETTLE_TIME_NS = 10000;
    localparam int CLK_MHZ        = 125;
    localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_W       = 11;

    // ****************************************
    // Modes, sources and bus phases
    // ****************************************
    typedef enum logic [2:0] {
        MODE_RESET        = 3'b000,
        MODE_THREE_COMMON = 3'b001,
        MODE_TWO_IND      = 3'b010,
        MODE_TWO_OUT      = 3'b011,
        MODE_TWO_COMMON   = 3'b100,
        MODE_ONE_ONLY     = 3'b101,
        MODE_INT_REF      = 3'b110,
        MODE_OFF          = 3'b111
    } mode_t;

    // Source codes 0..5 select one of the six shared pins
    localparam logic [2:0] SRC_VREF = 3'h6;
    localparam logic [2:0] SRC_NONE = 3'h7;

    typedef struct packed {
        logic [2:0] a_pos;
        logic [2:0] a_neg;
        logic [2:0] b_pos;
        logic [2:0] b_neg;
        logic       a_on;
        logic       b_on;
        logic       out_en;
        logic [5:0] analog_pins;
    } route_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WAIT = 2'b01,
        BUS_DONE = 2'b10
    } bus_phase_t;

endpackage

`default_nettype wire

// ===== cmp_link_if.sv
// Carrier between the control top and its route and settle modules
`default_nettype none

interface cmp_link_if;
    logic                 clk;
    logic                 rstn;
    logic [2:0]           mode;
    logic                 sw;
    logic                 inv_a;
    logic                 inv_b;
    cmp_pkg::route_t      route;
    logic                 raw_a;
    logic                 raw_b;
    logic                 result_a;
    logic                 result_b;
    logic                 settled;

    modport router (input clk, rstn, mode, sw, output route);
    modport settler (input clk, rstn, mode, inv_a, inv_b, route, raw_a, raw_b,
                     output result_a, result_b, settled);
    modport owner (output clk, rstn, mode, sw, inv_a, inv_b, raw_a, raw_b,
                   input route, result_a, result_b, settled);
endinterface

`default_nettype wire

// ===== cmp_route.sv
// Mode decoder that sets the comparator input and output multiplexers
`default_nettype none

module cmp_route (
    cmp_link_if.router link
);

    // ****************************************
    // Mode table
    // ****************************************
    function automatic cmp_pkg::route_t route_of(input cmp_pkg::mode_t m, input logic sw);
        cmp_pkg::route_t r;
        r = '{a_pos: cmp_pkg::SRC_NONE, a_neg: cmp_pkg::SRC_NONE, b_pos: cmp_pkg::SRC_NONE,
              b_neg: cmp_pkg::SRC_NONE, a_on: 1'b0, b_on: 1'b0, out_en: 1'b0,
              analog_pins: 6'h3f};
        case (m)
            cmp_pkg::MODE_RESET: begin
                r.analog_pins = 6'h3f;
            end
            cmp_pkg::MODE_THREE_COMMON: begin
                r = '{3'h2, 3'h0, 3'h2, 3'h3, 1'b1, 1'b1, 1'b0, 6'h0d};
            end
            cmp_pkg::MODE_TWO_IND: begin
                r = '{3'h0, 3'h1, 3'h2, 3'h3, 1'b1, 1'b1, 1'b0, 6'h0f};
            end
            cmp_pkg::MODE_TWO_OUT: begin
                r = '{3'h2, 3'h3, 3'h4, 3'h5, 1'b1, 1'b1, 1'b1, 6'h3c};
            end
            cmp_pkg::MODE_TWO_COMMON: begin
                r = '{3'h0, 3'h1, 3'h0, 3'h3, 1'b1, 1'b1, 1'b0, 6'h0b};
            end
            cmp_pkg::MODE_ONE_ONLY: begin
                r = '{cmp_pkg::SRC_NONE, cmp_pkg::SRC_NONE, 3'h2, 3'h3, 1'b0, 1'b1, 1'b0,
                      6'h0c};
            end
            cmp_pkg::MODE_INT_REF: begin
                // The switch picks the inverting pin pair only here
                r.a_pos = cmp_pkg::SRC_VREF; // RULE14
                r.b_pos = cmp_pkg::SRC_VREF; // RULE7
                r.a_neg = sw ? 3'h1 : 3'h0; // RULE15
                r.b_neg = sw ? 3'h3 : 3'h2; // RULE15
                r.a_on  = 1'b1;
                r.b_on  = 1'b1;
                r.analog_pins = 6'h0f; // RULE6
            end
            cmp_pkg::MODE_OFF: begin
                r.analog_pins = 6'h00;
            end
            default: begin
                r.analog_pins = 6'h3f;
            end
        endcase
        return r;
    endfunction

    always_comb begin
        link.route = route_of(cmp_pkg::mode_t'(link.mode), link.sw); // RULE4
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_int_ref_pos: assert property (@(posedge link.clk) disable iff (!link.rstn) // RULE14
        (link.mode == cmp_pkg::MODE_INT_REF) |->
        (link.route.a_pos == cmp_pkg::SRC_VREF && link.route.b_pos == cmp_pkg::SRC_VREF))
        else $error("Reference not on both non-inverting inputs");

    chk_switch_ignored: assert property (@(posedge link.clk) disable iff (!link.rstn) // RULE15
        (link.mode != cmp_pkg::MODE_INT_REF && $stable(link.mode) && $changed(link.sw)) |->
        $stable(link.route))
        else $error("Input switch changed routing outside reference mode");

endmodule // cmp_route

`default_nettype wire

// ===== cmp_settle.sv
// Result sampling, inversion and settling guard after a mode change
`default_nettype none

module cmp_settle (
    cmp_link_if.settler link
);

    typedef struct packed {
        logic [cmp_pkg::SETTLE_W-1:0] count;
        logic                         settled;
        logic                         res_a;
        logic                         res_b;
        logic [2:0]                   last_mode;
    } settle_state_t;

    localparam logic [cmp_pkg::SETTLE_W-1:0] LOAD =
        cmp_pkg::SETTLE_W'(cmp_pkg::SETTLE_CYCLES - 1);

    settle_state_t s_r;
    settle_state_t s_nxt;
    logic          chg;

    assign chg = (link.mode != s_r.last_mode);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.last_mode = link.mode;
        if (chg) begin
            s_nxt.count = LOAD; // RULE8
        end else if (s_r.count != '0) begin
            s_nxt.count = s_r.count - 1'b1;
        end
        s_nxt.settled = (s_nxt.count == '0) && !chg; // RULE8
        // Results are frozen while settling so software never sees glitches
        if (s_r.settled && !chg) begin
            s_nxt.res_a = link.route.a_on & (link.raw_a ^ link.inv_a); // RULE2 RULE3 RULE11
            s_nxt.res_b = link.route.b_on & (link.raw_b ^ link.inv_b); // RULE1 RULE11
        end
    end

    always_ff @(posedge link.clk) begin
        if (!link.rstn) begin
            s_r <= '{count: '0, settled: 1'b1, res_a: 1'b0, res_b: 1'b0, last_mode: 3'b000};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.result_a = s_r.res_a;
    assign link.result_b = s_r.res_b;
    assign link.settled  = s_r.settled;

    // ****************************************
    // Checks
    // ****************************************
    chk_result_follow: assert property (@(posedge link.clk) disable iff (!link.rstn) // RULE11
        (s_r.settled && !chg && link.route.a_on) |=>
        (link.result_a == $past(link.raw_a ^ link.inv_a)))
        else $error("Result A does not follow raw input and inversion");

    chk_settle_start: assert property (@(posedge link.clk) disable iff (!link.rstn) // RULE8
        chg |=> (!link.settled && s_r.count == LOAD))
        else $error("Mode change did not start the settling delay");

    chk_settle_end: assert property (@(posedge link.clk) disable iff (!link.rstn) // RULE8
        (!link.settled && s_r.count == 11'h001 && !chg) |=> link.settled)
        else $error("Settling did not end on time");

endmodule // cmp_settle

`default_nettype wire

// ===== dual_comparator_control.sv
// Top of the dual comparator control block with its AHB-Lite register slave
// Operation
// RULE1: Two comparators, each result sampled for software
// RULE2: Raw result high when plus exceeds minus
// RULE3: Raw result low when plus below minus
// RULE4: Three-bit mode field picks eight configurations
// RULE5: Control register drives input and output muxes
// RULE6: Inputs come from six shared pins
// RULE7: Internal reference selectable as input source
// RULE8: Results invalid until settling delay elapses
// RULE9: Software disables comparator interrupt during mode change
// RULE10: Software sets pin directions; block never overrides
// RULE11: Inversion bit flips each reported result
// RULE12: Result bits read-only; writes ignored
// RULE13: Reset clears control register, comparators off
// RULE14: Reference mode feeds both non-inverting inputs
// RULE15: Switch picks inverting pair only in reference mode
// RULE16: Bits: results 7:6, invert 5:4, switch 3, mode 2:0
//
// The register addresses and register access over AHB-Lite are this design's own decisions.
`default_nettype none

module dual_comparator_control (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    input  wire logic        cmp_a_raw,
    input  wire logic        cmp_b_raw,
    output var  logic [2:0]  cmp_a_pos_sel,
    output var  logic [2:0]  cmp_a_neg_sel,
    output var  logic [2:0]  cmp_b_pos_sel,
    output var  logic [2:0]  cmp_b_neg_sel,
    output var  logic        cmp_a_power,
    output var  logic        cmp_b_power,
    output var  logic        out_mux_en,
    output var  logic [5:0]  pin_analog_en,
    output var  logic        cmp_a_pin_out,
    output var  logic        cmp_b_pin_out
);

    typedef struct packed {
        cmp_pkg::bus_phase_t phase;
        logic [7:0]          addr;
        logic                write;
        logic [5:0]          ctrl;
        logic [31:0]         rdata;
        logic                ready;
        cmp_pkg::route_t     route;
        logic                pin_a;
        logic                pin_b;
    } top_state_t;

    top_state_t s_r;
    top_state_t s_nxt;
    logic       take;
    cmp_link_if link ();

    // ****************************************
    // Submodules
    // ****************************************
    assign link.clk   = core_clk;
    assign link.rstn  = rstn;
    assign link.mode  = s_r.ctrl[cmp_pkg::MODE_MSB:cmp_pkg::MODE_LSB];
    assign link.sw    = s_r.ctrl[cmp_pkg::SWITCH_BIT];
    assign link.inv_a = s_r.ctrl[cmp_pkg::INV_A_BIT];
    assign link.inv_b = s_r.ctrl[cmp_pkg::INV_B_BIT];
    assign link.raw_a = cmp_a_raw;
    assign link.raw_b = cmp_b_raw;

    cmp_route u_route (
        .link (link.router)
    );

    cmp_settle u_settle (
        .link (link.settler)
    );

    // ****************************************
    // Register read decode
    // ****************************************
    function automatic logic [31:0] read_word(input logic [7:0] a, input logic [5:0] c,
                                              input logic ra, input logic rb,
                                              input logic st);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == cmp_pkg::CTRL_OFFSET) begin
            w[5:0] = c;
            w[cmp_pkg::RES_A_BIT] = ra; // RULE16
            w[cmp_pkg::RES_B_BIT] = rb; // RULE16
        end else if (a == cmp_pkg::STATUS_OFFSET) begin
            w[cmp_pkg::SETTLED_BIT] = st;
        end
        return w;
    endfunction

    // ****************************************
    // Bus slave and output staging
    // ****************************************
    // Every transfer takes one wait state so a read sees any write just before it
    assign take = hsel && hready && htrans[1];

    always_comb begin
        s_nxt = s_r;
        s_nxt.ready = 1'b1;
        case (s_r.phase)
            cmp_pkg::BUS_IDLE, cmp_pkg::BUS_DONE: begin
                if (take) begin
                    s_nxt.phase = cmp_pkg::BUS_WAIT;
                    s_nxt.addr  = haddr[7:0];
                    s_nxt.write = hwrite;
                    s_nxt.ready = 1'b0;
                end else begin
                    s_nxt.phase = cmp_pkg::BUS_IDLE;
                end
            end
            cmp_pkg::BUS_WAIT: begin
                s_nxt.phase = cmp_pkg::BUS_DONE;
                if (s_r.write) begin
                    if (s_r.addr == cmp_pkg::CTRL_OFFSET) begin
                        // Result bits are not stored, so writes there vanish
                        s_nxt.ctrl = hwdata[5:0]; // RULE12 RULE16
                    end
                end else begin
                    s_nxt.rdata = read_word(s_r.addr, s_r.ctrl, link.result_a,
                                            link.result_b, link.settled);
                end
            end
            default: begin
                s_nxt.phase = cmp_pkg::BUS_IDLE;
            end
        endcase
        s_nxt.route = link.route; // RULE5
        s_nxt.pin_a = link.route.out_en & link.result_a;
        s_nxt.pin_b = link.route.out_en & link.result_b;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s_r <= '{phase: cmp_pkg::BUS_IDLE, addr: 8'h00, write: 1'b0,
                     ctrl: cmp_pkg::CTRL_RESET[5:0], rdata: 32'h0000_0000, ready: 1'b1,
                     route: '{cmp_pkg::SRC_NONE, cmp_pkg::SRC_NONE, cmp_pkg::SRC_NONE,
                              cmp_pkg::SRC_NONE, 1'b0, 1'b0, 1'b0, 6'h3f},
                     pin_a: 1'b0, pin_b: 1'b0}; // RULE13
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign hrdata        = s_r.rdata;
    assign hreadyout     = s_r.ready;
    assign hresp         = 1'b0;
    assign cmp_a_pos_sel = s_r.route.a_pos;
    assign cmp_a_neg_sel = s_r.route.a_neg;
    assign cmp_b_pos_sel = s_r.route.b_pos;
    assign cmp_b_neg_sel = s_r.route.b_neg;
    assign cmp_a_power   = s_r.route.a_on;
    assign cmp_b_power   = s_r.route.b_on;
    assign out_mux_en    = s_r.route.out_en;
    // Pin direction stays with the port logic; only level and enable leave here
    assign pin_analog_en = s_r.route.analog_pins; // RULE10
    assign cmp_a_pin_out = s_r.pin_a;
    assign cmp_b_pin_out = s_r.pin_b;

    // ****************************************
    // Checks
    // ****************************************
    chk_reset_clear: assert property (@(posedge core_clk) disable iff (!rstn) // RULE13
        $past(!rstn) |-> (s_r.ctrl == 6'h00 && !cmp_a_power && !cmp_b_power &&
                          pin_analog_en == 6'h3f && hreadyout))
        else $error("Reset did not clear the control register");

    chk_write_ctrl: assert property (@(posedge core_clk) disable iff (!rstn) // RULE12
        (s_r.phase == cmp_pkg::BUS_WAIT && s_r.write && s_r.addr == cmp_pkg::CTRL_OFFSET)
        |=> (s_r.ctrl == $past(hwdata[5:0]) && hreadyout))
        else $error("Control write not stored at bits 5:0");

    chk_read_ctrl: assert property (@(posedge core_clk) disable iff (!rstn) // RULE16
        (s_r.phase == cmp_pkg::BUS_WAIT && !s_r.write && s_r.addr == cmp_pkg::CTRL_OFFSET)
        |=> (hreadyout && hrdata[7:6] == $past({link.result_b, link.result_a}) &&
             hrdata[5:0] == $past(s_r.ctrl) && hrdata[31:8] == 24'h000000))
        else $error("Control read returned wrong layout");

    chk_route_mux: assert property (@(posedge core_clk) disable iff (!rstn) // RULE5
        ($stable(s_r.ctrl) && s_r.ctrl[2:0] == 3'b111) |=>
        (!cmp_a_power && !cmp_b_power && pin_analog_en == 6'h00))
        else $error("Off mode did not power down the comparators");

    chk_wait_state: assert property (@(posedge core_clk) disable iff (!rstn)
        (take && s_r.phase != cmp_pkg::BUS_WAIT) |=> (!hreadyout ##1 hreadyout))
        else $error("Transfer did not take exactly one wait state");

endmodule // dual_comparator_control

`default_nettype wire

// ===== cmp_far_model.sv
// Behavioural model of the two analog comparators and their six shared input pins
`default_nettype none

module cmp_far_model (
    input  wire logic             core_clk,
    input  wire logic [2:0]       a_pos_sel,
    input  wire logic [2:0]       a_neg_sel,
    input  wire logic [2:0]       b_pos_sel,
    input  wire logic [2:0]       b_neg_sel,
    input  wire logic             a_power,
    input  wire logic             b_power,
    input  wire logic [5:0][11:0] pin_mv,
    input  wire logic [11:0]      vref_mv,
    output var  logic             a_raw,
    output var  logic             b_raw
);
    // ****************************************
    // Analog levels and comparison
    // ****************************************
    function automatic logic [11:0] level(input logic [2:0] sel);
        if (sel < 3'h6) begin
            return pin_mv[sel];
        end
        return (sel == 3'h6) ? vref_mv : 12'h000;
    endfunction

    initial begin
        a_raw = 1'b0;
        b_raw = 1'b0;
    end

    // An unpowered comparator has no valid output, so it toggles to expose any leak
    always @(posedge core_clk) begin
        a_raw <= a_power ? (level(a_pos_sel) > level(a_neg_sel)) : ~a_raw;
        b_raw <= b_power ? (level(b_pos_sel) > level(b_neg_sel)) : ~b_raw;
    end
endmodule // cmp_far_model

`default_nettype wire

// ===== tb.sv
// Self-checking testbench of the dual comparator control block
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic             core_clk, rstn, hsel, hwrite, hreadyout, hresp;
    logic             a_raw, b_raw, a_pow, b_pow, out_en, a_pin, b_pin;
    logic [31:0]      haddr, hwdata, hrdata, rd;
    logic [1:0]       htrans;
    logic [2:0]       hsize, a_pos, a_neg, b_pos, b_neg;
    logic [5:0]       analog;
    logic [5:0][11:0] pin_mv;
    logic [11:0]      vref_mv;
    int               failures, num_checks;

    dual_comparator_control DUT (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cmp_a_raw(a_raw), .cmp_b_raw(b_raw), .cmp_a_pos_sel(a_pos), .cmp_a_neg_sel(a_neg),
        .cmp_b_pos_sel(b_pos), .cmp_b_neg_sel(b_neg), .cmp_a_power(a_pow),
        .cmp_b_power(b_pow), .out_mux_en(out_en), .pin_analog_en(analog),
        .cmp_a_pin_out(a_pin), .cmp_b_pin_out(b_pin));

    cmp_far_model far (.core_clk(core_clk), .a_pos_sel(a_pos), .a_neg_sel(a_neg),
        .b_pos_sel(b_pos), .b_neg_sel(b_neg), .a_power(a_pow), .b_power(b_pow),
        .pin_mv(pin_mv), .vref_mv(vref_mv), .a_raw(a_raw), .b_raw(b_raw));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic hang(input string what);
        failures++;
        $display("mismatch %s expected done seen timeout", what);
        end_of_test();
    endtask

    // Address phase held until hready is seen high, then data phase likewise
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) hang("bus address");
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) hang("bus data");
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wait_settled();
        int n;
        n = 0;
        do begin
            bus(1'b0, 8'h04, 32'h0);
            n++;
        end while (rd[0] !== 1'b1 && n < 1000);
        if (rd[0] !== 1'b1) hang("settle");
    endtask

    function automatic logic [31:0] route(input logic [2:0] m);
        case (m)
            // Selects are four 3-bit fields: A plus, A minus, B plus, B minus
            3'd1: return {11'h0, 3'h2, 3'h0, 3'h2, 3'h3, 3'b110, 6'h0d};
            3'd2: return {11'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'b110, 6'h0f};
            3'd3: return {11'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'b111, 6'h3c};
            3'd4: return {11'h0, 3'h0, 3'h1, 3'h0, 3'h3, 3'b110, 6'h0b};
            3'd5: return {11'h0, 3'h7, 3'h7, 3'h2, 3'h3, 3'b010, 6'h0c};
            3'd6: return {11'h0, 3'h6, 3'h0, 3'h6, 3'h2, 3'b110, 6'h0f};
            3'd7: return {11'h0, 3'h7, 3'h7, 3'h7, 3'h7, 3'b000, 6'h00};
            default: return {11'h0, 3'h7, 3'h7, 3'h7, 3'h7, 3'b000, 6'h3f};
        endcase
    endfunction

    function automatic logic [31:0] outs();
        return {11'h0, a_pos, a_neg, b_pos, b_neg, a_pow, b_pow, out_en, analog};
    endfunction

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        bus(1'b0, 8'h00, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        chk("route reset", route(3'd0), outs());
    endtask

    task automatic t_modes();
        for (int m = 0; m < 8; m++) begin
            bus(1'b1, 8'h00, m);
            @(posedge core_clk);
            chk("route", route(m[2:0]), outs());
            bus(1'b0, 8'h00, 32'h0);
            chk("mode", m, rd & 32'h3f);
        end
    endtask

    task automatic t_switch();
        bus(1'b1, 8'h00, 32'h09);
        @(posedge core_clk);
        chk("switch ignored", route(3'd1), outs());
        bus(1'b1, 8'h00, 32'h0e);
        @(posedge core_clk);
        chk("switch ref", {11'h0, 3'h6, 3'h1, 3'h6, 3'h3, 3'b110, 6'h0f}, outs());
    endtask

    task automatic t_results();
        pin_mv[0] <= 12'd600;
        pin_mv[1] <= 12'd400;
        pin_mv[2] <= 12'd100;
        pin_mv[3] <= 12'd900;
        bus(1'b1, 8'h00, 32'h02);
        bus(1'b0, 8'h04, 32'h0);
        chk("status", 32'h0, rd);
        wait_settled();
        bus(1'b0, 8'h00, 32'h0);
        chk("results", 32'h42, rd);
        bus(1'b1, 8'h00, 32'h32);
        repeat (3) @(posedge core_clk);
        bus(1'b0, 8'h00, 32'h0);
        chk("inverted", 32'hb2, rd);
        bus(1'b1, 8'h00, 32'h04);
        bus(1'b0, 8'h00, 32'h0);
        chk("frozen", 32'h84, rd);
        wait_settled();
        bus(1'b0, 8'h00, 32'h0);
        chk("new mode", 32'h44, rd);
    endtask

    task automatic t_ref();
        vref_mv <= 12'd500;
        bus(1'b1, 8'h00, 32'hce);
        wait_settled();
        bus(1'b0, 8'h00, 32'h0);
        chk("ref sw1", 32'h4e, rd);
        bus(1'b1, 8'h00, 32'h06);
        wait_settled();
        bus(1'b0, 8'h00, 32'h0);
        chk("ref sw0", 32'h86, rd);
    endtask

    task automatic t_pins();
        pin_mv[4] <= 12'd700;
        pin_mv[5] <= 12'd200;
        bus(1'b1, 8'h00, 32'h03);
        wait_settled();
        repeat (3) @(posedge core_clk);
        chk("pin outs", 32'h1, {30'h0, a_pin, b_pin});
        bus(1'b0, 8'h00, 32'h0);
        chk("pin mode", 32'h83, rd);
        bus(1'b1, 8'h08, 32'hff);
        bus(1'b0, 8'h08, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b0, 8'h00, 32'h0);
        chk("ctrl kept", 32'h83, rd);
    endtask

    task automatic t_rereset();
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        chk("route rereset", route(3'd0), outs());
        bus(1'b0, 8'h00, 32'h0);
        chk("ctrl rereset", 32'h0, rd);
    endtask

    initial begin
        failures   = 0;
        num_checks = 0;
        rstn       = 1'b0;
        hsel       = 1'b0;
        haddr      = 32'h0;
        htrans     = 2'b00;
        hwrite     = 1'b0;
        hsize      = 3'h2;
        hwdata     = 32'h0;
        pin_mv     = '0;
        vref_mv    = 12'h000;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_modes();
        t_switch();
        t_results();
        t_ref();
        t_pins();
        t_rereset();
        end_of_test();
    end
endmodule // tb

`default_nettype wire
